/* verilog/wwd_pkg.sv */
// window watchdog package: register map, field layout, reset values, timing
package wwd_pkg;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CounterControlOffset    = 8'h00;
  localparam logic [7:0] WindowConfigOffset      = 8'h04;
  localparam logic [7:0] EarlyWarningStatusOffset = 8'h08;
  localparam logic [7:0] IrqStatusOffset         = 8'h0C;
  localparam logic [7:0] IrqMaskOffset           = 8'h10;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CountMsb        = 6;
  localparam int ActivateBit     = 7;
  localparam int DividerLsb      = 7;
  localparam int DividerMsb      = 8;
  localparam int IrqEnableBit    = 9;
  localparam int AlertFlagBit    = 0;
  localparam int IrqCountReached = 0;
  localparam int IrqEarlyRefresh = 1;
  localparam int IrqResetReq     = 2;
  localparam int IrqWidth        = 3;

  // ---------------------------------------------------------------------------
  // reset values and thresholds
  // ---------------------------------------------------------------------------
  localparam logic [6:0] CountReset   = 7'h7F;
  localparam logic [6:0] WindowReset  = 7'h7F;
  localparam logic [6:0] WarnCount    = 7'h40;
  localparam logic [IrqWidth-1:0] IrqMaskReset = 3'h0;

  // ---------------------------------------------------------------------------
  // time base: fixed predivider of 4096 bus clocks
  // ---------------------------------------------------------------------------
  localparam int         PreDivide    = 4096;
  localparam int         PreWidth     = 12;
  localparam logic [11:0] PreLast     = 12'(PreDivide - 1);

endpackage : wwd_pkg

/* verilog/wwd_tick_gen.sv */
// time base generator: bus clock divided by 4096, then by 1, 2, 4 or 8
`timescale 1ns/10ps
module wwd_tick_gen (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [1:0] dividerExponent,
  // tick out
  output logic            tick
);

  logic [wwd_pkg::PreWidth-1:0] preCnt_reg;
  logic [2:0]                   postCnt_reg;
  logic [2:0]                   postMask;
  wire                          preWrap;
  wire                          postWrap;

  // post divider wraps after 2^exponent pre ticks
  assign postMask = 3'((4'h1 << dividerExponent) - 4'h1);
  assign preWrap  = run && (preCnt_reg == wwd_pkg::PreLast);
  assign postWrap = (postCnt_reg & postMask) == postMask;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preCnt_reg  <= '0;
      postCnt_reg <= 3'h0;
      tick        <= 1'b0;
    end else begin
      tick <= preWrap && postWrap;
      if (run) begin
        preCnt_reg <= preWrap ? '0 : preCnt_reg + 1'b1;
      end
      if (preWrap) begin
        postCnt_reg <= postWrap ? 3'h0 : postCnt_reg + 3'h1;
      end
    end
  end

endmodule : wwd_tick_gen

/* verilog/window_watchdog.sv */
// window watchdog top: registers, downcounter, reset request and interrupt
// Operation
// - 7-bit downcounter runs once activated
// - counter field reads live, write reloads
// - reset when counter falls 0x40 to 0x3F
// - reset on reload above window value
// - reload inside window with bit 6 set gives no reset
// - disabled after reset until activate set
// - activate bit set-only, reset clears it
// - time base is bus clock/4096/2^code
// - timeout scales with low six bits plus one
// - early flag set at 0x40 or early reload
// - early flag cleared by writing zero
// - enable bit routes early condition to interrupt
// - irq enable set-only, cleared by resets
// - window field holds premature refresh threshold
// - debug halt freezes counter when enabled
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module window_watchdog (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // software reset from the clock controller; clears only the early alert irq enable
  input  wire logic        unitSoftReset,
  // debug
  input  wire logic        coreHalted,
  input  wire logic        haltOnDebug,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // system outputs
  output logic             systemResetReq,
  output logic             irq,
  output logic             earlyAlertIrq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [6:0]                   downCountValue_reg;
  logic                         watchdogActivate_reg;
  logic [6:0]                   refreshLimit_reg;
  logic [1:0]                   tickDividerSelect_reg;
  logic                         earlyAlertIrqEnable_reg;
  logic                         earlyAlertFlag_reg;
  logic [wwd_pkg::IrqWidth-1:0] irqStatus_reg;
  logic [wwd_pkg::IrqWidth-1:0] irqMask_reg;
  logic                         tick;

  // ---------------------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------------------
  logic [6:0]                   downCountValue_next;
  logic                         watchdogActivate_next;
  logic [6:0]                   refreshLimit_next;
  logic [1:0]                   tickDividerSelect_next;
  logic                         earlyAlertIrqEnable_next;
  logic                         earlyAlertFlag_next;
  logic [wwd_pkg::IrqWidth-1:0] irqStatus_next;
  logic [wwd_pkg::IrqWidth-1:0] irqMask_next;
  logic                         systemResetReq_next;
  logic                         irq_next;
  logic                         earlyAlertIrq_next;
  logic [31:0]                  regRdData_next;

  // ---------------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------------
  // exact byte address match; a partial decode would alias registers
  function automatic logic addrHit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    return addr == offset;
  endfunction : addrHit

  // sticky bits: an event in the same cycle as a clear keeps the bit set
  function automatic logic [wwd_pkg::IrqWidth-1:0] stickyNext(
    input logic [wwd_pkg::IrqWidth-1:0] cur,
    input logic [wwd_pkg::IrqWidth-1:0] clr,
    input logic [wwd_pkg::IrqWidth-1:0] set
  );
    return (cur & ~clr) | set;
  endfunction : stickyNext

  // set-only control bit: software can raise it, only a reset lowers it
  function automatic logic setOnlyNext(
    input logic cur,
    input logic setWr
  );
    return cur || setWr;
  endfunction : setOnlyNext

  // early alert flag: a written zero clears it, the event wins
  function automatic logic alertFlagNext(
    input logic cur,
    input logic set,
    input logic zeroWr
  );
    return set || (cur && !zeroWr);
  endfunction : alertFlagNext

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  wire selCtrl   = addrHit(regAddr, wwd_pkg::CounterControlOffset);
  wire selCfg    = addrHit(regAddr, wwd_pkg::WindowConfigOffset);
  wire selStat   = addrHit(regAddr, wwd_pkg::EarlyWarningStatusOffset);
  wire selIrqSt  = addrHit(regAddr, wwd_pkg::IrqStatusOffset);
  wire selIrqMsk = addrHit(regAddr, wwd_pkg::IrqMaskOffset);

  wire wrCtrl   = regWrite && selCtrl;
  wire wrCfg    = regWrite && selCfg;
  wire wrStat   = regWrite && selStat;
  wire wrIrqSt  = regWrite && selIrqSt;
  wire wrIrqMsk = regWrite && selIrqMsk;

  // write data fields, named once so each register picks its own slice
  wire [6:0] wrCount     = regWrData[wwd_pkg::CountMsb:0];
  wire [6:0] wrWindow    = regWrData[wwd_pkg::CountMsb:0];
  wire       wrActivate  = regWrData[wwd_pkg::ActivateBit];
  wire [1:0] wrDivider   = regWrData[wwd_pkg::DividerMsb:wwd_pkg::DividerLsb];
  wire       wrIrqEnable = regWrData[wwd_pkg::IrqEnableBit];
  wire       wrFlagZero  = !regWrData[wwd_pkg::AlertFlagBit];
  wire [wwd_pkg::IrqWidth-1:0] wrIrqBits = regWrData[wwd_pkg::IrqWidth-1:0];

  // ---------------------------------------------------------------------------
  // counter events
  // ---------------------------------------------------------------------------
  // a frozen core in debug stops the time base as well, so the prescaler holds its count
  wire running    = watchdogActivate_reg && !(haltOnDebug && coreHalted);
  wire decStep    = running && tick;
  wire hitWarn    = decStep && (downCountValue_reg == 7'(wwd_pkg::WarnCount + 7'h01));
  wire hitExpire  = decStep && (downCountValue_reg == wwd_pkg::WarnCount);
  wire earlyWrite = wrCtrl && watchdogActivate_reg &&
                    (downCountValue_reg > refreshLimit_reg);
  // activation in the same write that loads a low count still triggers at once
  wire lowLoad    = wrCtrl && (watchdogActivate_reg || regWrData[wwd_pkg::ActivateBit]) &&
                    !wrCount[wwd_pkg::CountMsb];
  wire alertEvent = hitWarn || earlyWrite;
  wire resetEvent = hitExpire || earlyWrite || lowLoad;

  wire [wwd_pkg::IrqWidth-1:0] irqEvents = {resetEvent, earlyWrite, hitWarn};
  wire [wwd_pkg::IrqWidth-1:0] irqClear  = wrIrqSt ? wrIrqBits : '0;

  // ---------------------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------------------
  wwd_tick_gen i_wwd_tick_gen (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .run             (running),
    .dividerExponent (tickDividerSelect_reg),
    .tick            (tick)
  );

  // ---------------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------------
  // a reload takes priority over a tick that lands in the same cycle
  assign downCountValue_next   = wrCtrl  ? wrCount :
                                 decStep ? 7'(downCountValue_reg - 7'h01) : downCountValue_reg;
  assign watchdogActivate_next = setOnlyNext(watchdogActivate_reg, wrCtrl && wrActivate);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      downCountValue_reg   <= wwd_pkg::CountReset;
      watchdogActivate_reg <= 1'b0;
    end else begin
      downCountValue_reg   <= downCountValue_next;
      watchdogActivate_reg <= watchdogActivate_next;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------------------
  assign refreshLimit_next      = wrCfg ? wrWindow : refreshLimit_reg;
  assign tickDividerSelect_next = wrCfg ? wrDivider : tickDividerSelect_reg;
  // the clock controller's soft reset outranks a set in the same cycle
  assign earlyAlertIrqEnable_next = !unitSoftReset &&
                                    setOnlyNext(earlyAlertIrqEnable_reg, wrCfg && wrIrqEnable);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refreshLimit_reg        <= wwd_pkg::WindowReset;
      tickDividerSelect_reg   <= 2'h0;
      earlyAlertIrqEnable_reg <= 1'b0;
    end else begin
      refreshLimit_reg        <= refreshLimit_next;
      tickDividerSelect_reg   <= tickDividerSelect_next;
      earlyAlertIrqEnable_reg <= earlyAlertIrqEnable_next;
    end
  end

  // ---------------------------------------------------------------------------
  // early alert flag: set wins over a write of zero in the same cycle
  // ---------------------------------------------------------------------------
  assign earlyAlertFlag_next = alertFlagNext(earlyAlertFlag_reg, alertEvent, wrStat && wrFlagZero);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      earlyAlertFlag_reg <= 1'b0;
    end else begin
      earlyAlertFlag_reg <= earlyAlertFlag_next;
    end
  end

  // ---------------------------------------------------------------------------
  // general event status, write one to clear, and mask, written directly
  // ---------------------------------------------------------------------------
  assign irqStatus_next = stickyNext(irqStatus_reg, irqClear, irqEvents);
  assign irqMask_next   = wrIrqMsk ? wrIrqBits : irqMask_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStatus_reg <= '0;
      irqMask_reg   <= wwd_pkg::IrqMaskReset;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irqMask_reg   <= irqMask_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign systemResetReq_next = resetEvent;
  // built from next values so the level outputs do not lag their registers
  assign irq_next            = |(irqStatus_next & irqMask_next);
  assign earlyAlertIrq_next  = earlyAlertIrqEnable_next && earlyAlertFlag_next;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      systemResetReq <= 1'b0;
      irq            <= 1'b0;
      earlyAlertIrq  <= 1'b0;
    end else begin
      systemResetReq <= systemResetReq_next;
      irq            <= irq_next;
      earlyAlertIrq  <= earlyAlertIrq_next;
    end
  end

  // ---------------------------------------------------------------------------
  // read path, one cycle after the strobe
  // ---------------------------------------------------------------------------
  wire [31:0] rdCtrlWord   = {24'h000000, watchdogActivate_reg, downCountValue_reg};
  wire [31:0] rdCfgWord    = {22'h000000, earlyAlertIrqEnable_reg, tickDividerSelect_reg, refreshLimit_reg};
  wire [31:0] rdStatWord   = {31'h00000000, earlyAlertFlag_reg};
  wire [31:0] rdIrqStWord  = {29'h00000000, irqStatus_reg};
  wire [31:0] rdIrqMskWord = {29'h00000000, irqMask_reg};

  // selects are one-hot by exact decode; an unmapped address reads zero
  wire [31:0] rdMux = ({32{selCtrl}}   & rdCtrlWord)  |
                      ({32{selCfg}}    & rdCfgWord)   |
                      ({32{selStat}}   & rdStatWord)  |
                      ({32{selIrqSt}}  & rdIrqStWord) |
                      ({32{selIrqMsk}} & rdIrqMskWord);

  // zero outside a read so a stale word never lingers on the bus
  assign regRdData_next = regRead ? rdMux : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRdData_next;
    end
  end

endmodule : window_watchdog

/* verification/wwd_monitor.sv */
// port checker for the window watchdog
`timescale 1ns/10ps
module wwd_monitor (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // inputs
  input wire logic        unitSoftReset,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  // outputs
  input wire logic [31:0] regRdData,
  input wire logic        systemResetReq,
  input wire logic        irq,
  input wire logic        earlyAlertIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  property p_pulse; systemResetReq |=> !systemResetReq; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_low; regWrite && regAddr == 8'h00 && regWrData[7] && !regWrData[6] |-> ##[1:2] systemResetReq; endproperty
  a_low: assert property (p_low) else $error("low load gave no reset");
  property p_idle; !regRead |=> regRdData == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_unmap; regRead && regAddr > 8'h10 |=> regRdData == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_cfg; regRead && regAddr == 8'h04 |=> regRdData[31:10] == 22'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("config spare bits set");
  property p_ctrl; regRead && regAddr == 8'h00 |=> regRdData[31:8] == 24'h0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control spare bits set");
  property p_soft; unitSoftReset ##1 !regWrite |=> !earlyAlertIrq; endproperty
  a_soft: assert property (p_soft) else $error("alert irq after soft reset");
  property p_mask; regWrite && regAddr == 8'h10 && regWrData[2:0] == 3'h0 ##1 !regWrite |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq with all masked");
  property p_rel; $fell(rst) |-> !systemResetReq && !irq && !earlyAlertIrq; endproperty
  a_rel: assert property (p_rel) else $error("output busy after reset");
endmodule : wwd_monitor

bind window_watchdog wwd_monitor i_wwd_monitor (.sys_clk(sys_clk), .rst(rst), .unitSoftReset(unitSoftReset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .systemResetReq(systemResetReq), .irq(irq), .earlyAlertIrq(earlyAlertIrq));

/* verification/tb_window_watchdog.sv */
// self-checking testbench of the window watchdog
`timescale 1ns/10ps
module tb_window_watchdog;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        unitSoftReset = 1'b0;
  logic        coreHalted = 1'b0;
  logic        haltOnDebug = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic        systemResetReq;
  logic        irq;
  logic        earlyAlertIrq;
  logic [31:0] rdVal;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          rstPulses = 0;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (systemResetReq === 1'b1) rstPulses <= rstPulses + 1;

  window_watchdog i_window_watchdog (.sys_clk(sys_clk), .rst(rst), .unitSoftReset(unitSoftReset),
    .coreHalted(coreHalted), .haltOnDebug(haltOnDebug), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .systemResetReq(systemResetReq),
    .irq(irq), .earlyAlertIrq(earlyAlertIrq));
  // ----
  // helpers
  // ----
  task automatic report_and_stop;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
    chk(n, e, rdVal);
  endtask : rdChk

  task automatic doReset;
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : doReset

  // counts settled cycles until reset request (pick) or alert irq is high
  task automatic waitSig(input logic pick, output int n);
    n = 0;
    while ((pick ? systemResetReq : earlyAlertIrq) !== 1'b1 && n < 40000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("wait", 1'b1, n < 40000);
  endtask : waitSig
  // ----
  // scenarios
  // ----
  task automatic sRegs;
    rdChk(8'h00, 32'h7F, "ctrl");
    rdChk(8'h04, 32'h7F, "cfg");
    rdChk(8'h08, 32'h0, "status");
    rdChk(8'h10, 32'h0, "mask");
    rdChk(8'h20, 32'h0, "unmapped");
    wr(8'h04, 32'h3D5);
    rdChk(8'h04, 32'h3D5, "cfg wr");
    wr(8'h04, 32'h12);
    rdChk(8'h04, 32'h212, "irq en kept");
    @(posedge sys_clk);
    unitSoftReset <= 1'b1;
    @(posedge sys_clk);
    unitSoftReset <= 1'b0;
    rdChk(8'h04, 32'h12, "soft rst");
    repeat (5000) @(posedge sys_clk);
    rdChk(8'h00, 32'h7F, "idle ctrl");
  endtask : sRegs

  task automatic sTimeout(input logic [1:0] sel);
    int n;
    int p;
    doReset;
    wr(8'h04, {22'h0, 1'b1, sel, 7'h7F});
    wr(8'h00, 32'hC1);
    wr(8'h00, 32'h41);
    rdChk(8'h00, 32'hC1, "still active");
    p = rstPulses;
    waitSig(1'b0, n);
    chk("no rst", p, rstPulses);
    waitSig(1'b1, n);
    chk("tick span", 32'h0000_1000 << sel, n);
    rdChk(8'h08, 32'h1, "flag");
    chk("one rst", p + 1, rstPulses);
    wr(8'h08, 32'h1);
    rdChk(8'h08, 32'h1, "flag w1");
    chk("alert irq", 1'b1, earlyAlertIrq);
    wr(8'h08, 32'h0);
    rdChk(8'h08, 32'h0, "flag w0");
    chk("alert irq off", 1'b0, earlyAlertIrq);
  endtask : sTimeout

  task automatic sEarly;
    int p;
    doReset;
    wr(8'h10, 32'h2);
    wr(8'h04, 32'h50);
    wr(8'h00, 32'hFF);
    p = rstPulses;
    wr(8'h00, 32'h7F);
    rdChk(8'h08, 32'h1, "early flag");
    chk("early rst", p + 1, rstPulses);
    rdChk(8'h0C, 32'h6, "irq status");
    chk("irq", 1'b1, irq);
    wr(8'h0C, 32'h2);
    rdChk(8'h0C, 32'h4, "irq w1c");
    chk("irq off", 1'b0, irq);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h7F);
    wr(8'h00, 32'h60);
    rdChk(8'h00, 32'hE0, "in window");
    chk("no rst", p + 1, rstPulses);
    wr(8'h00, 32'h30);
    rdChk(8'h08, 32'h1, "flag kept");
    chk("low rst", p + 2, rstPulses);
  endtask : sEarly

  task automatic sDebug;
    doReset;
    haltOnDebug <= 1'b1;
    coreHalted <= 1'b1;
    wr(8'h00, 32'hFF);
    repeat (9000) @(posedge sys_clk);
    rdChk(8'h00, 32'hFF, "frozen");
    haltOnDebug <= 1'b0;
    repeat (9000) @(posedge sys_clk);
    rdChk(8'h00, 32'hFD, "running");
  endtask : sDebug

  initial begin
    #(95000 * 4);
    miscompares++;
    report_and_stop;
  end

  initial begin
    doReset;
    sRegs;
    for (int s = 0; s < 3; s++) begin
      sTimeout(2'(s));
    end
    sEarly;
    sDebug;
    report_and_stop;
  end
endmodule : tb_window_watchdog
